/* design/sfs_supervisor.sv */
// switcher fault supervisor: startup, soft-start, overload timer, lockouts
// Behaviour
// - below low supply level use reduced startup current, else nominal
// - enable drive pulses once supply reaches the turn-on level
// - ramp peak setpoint to maximum over the soft-start time
// - peak-limit flag high whenever setpoint sits at maximum
// - peak-limit flag rising starts the fault timer, nothing else does
// - flag still high at timer end stops pulses for eight periods
// - after off period retry one timer period, repeat while fault stays
// - retry ending without peak-limit flag returns to normal switching
// - undervoltage lockout stops pulses at once, over any timer state
// - block pulses while brown-out reports bulk image low
// - brown-out offset current on only while brown-out signal high
// - after brown-out in a pulsing state clears wait for turn-on level before pulsing; a brown-out within the off period does not
// - toggle startup source to hold supply during off and brown-out
// - brown-out pin above latch threshold latches off until reset
// - clamp overcurrent stops switching and waits a full off period
`include "sfs_consts.svh"

module sfs_supervisor #(
   parameter int TIMER_CYC = `SFS_TIMER_CYC,
   parameter int SOFTSTART_CYC = `SFS_SOFTSTART_CYC,
   parameter int OFF_PERIODS = `SFS_OFF_PERIODS
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic vcc_above_low_in,
   input wire logic vcc_at_on_in,
   input wire logic vcc_below_min_in,
   input wire logic bo_high_in,
   input wire logic bo_latch_in,
   input wire logic clamp_trip_in,
   output logic reduced_startup_current,
   output logic nominal_startup_current,
   output logic brownout_offset_current,
   output logic drive_enable,
   output logic [`SFS_SETPOINT_W-1:0] peak_setpoint,
   output logic peak_limit_flag,
   output logic fault_burst,
   output logic latched_off
);
   localparam int TW = $clog2(TIMER_CYC + 1);
   localparam int SSTEP = SOFTSTART_CYC / `SFS_SETPOINT_MAX;
   localparam int SW = $clog2(SSTEP + 2);
   localparam logic [TW-1:0] TIMER_LOAD = TW'(TIMER_CYC);
   localparam logic [SW-1:0] STEP_LOAD = SW'((SSTEP < 1) ? 1 : SSTEP);

   sfs_pkg::sfs_cmp_s cmp;
   sfs_pkg::sfs_state_e state_reg;
   sfs_pkg::sfs_state_e state_next;
   logic [3:0] periods_reg;
   logic [3:0] periods_next;
   logic [`SFS_SETPOINT_W-1:0] setpoint_reg;
   logic [`SFS_SETPOINT_W-1:0] setpoint_next;
   logic [SW-1:0] step_reg;
   logic [SW-1:0] step_next;
   logic timing_reg;
   logic timing_next;
   logic src_on_reg;
   logic src_on_next;
   logic flag_d_reg;
   logic flag_d_next;
   logic tmr_load;
   logic tmr_run;
   logic tmr_done;
   logic at_max;

   sfs_sync u_sync_low (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(vcc_above_low_in),
      .sync_out(cmp.vcc_above_low)
   );
   sfs_sync u_sync_on (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(vcc_at_on_in),
      .sync_out(cmp.vcc_at_on)
   );
   sfs_sync u_sync_min (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(vcc_below_min_in),
      .sync_out(cmp.vcc_below_min)
   );
   sfs_sync u_sync_bo (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(bo_high_in),
      .sync_out(cmp.bo_high)
   );
   sfs_sync u_sync_lat (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(bo_latch_in),
      .sync_out(cmp.bo_latch)
   );
   sfs_sync u_sync_ovp (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(clamp_trip_in),
      .sync_out(cmp.clamp_trip)
   );

   // shared 55 ms period counter
   // one counter serves the overload timer, off periods and retry
   sfs_counter #(.WIDTH(TW)) u_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .load(tmr_load),
      .period(TIMER_LOAD),
      .run(tmr_run),
      .done(tmr_done)
   );

   assign at_max = (setpoint_reg == `SFS_SETPOINT_MAX);

   // startup source hysteresis between min and turn-on levels
   always_comb begin
      src_on_next = src_on_reg;
      if (cmp.vcc_at_on) begin
         src_on_next = 1'b0;
      end else if (cmp.vcc_below_min) begin
         src_on_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         src_on_reg <= 1'b1;
      end else begin
         src_on_reg <= src_on_next;
      end
   end

   // flag history for the rising-edge test
   always_comb begin
      flag_d_next = at_max;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag_d_reg <= 1'b0;
      end else begin
         flag_d_reg <= flag_d_next;
      end
   end

   // main sequencer: start, ramp, overload timer and lockouts
   always_comb begin
      state_next = state_reg;
      periods_next = periods_reg;
      setpoint_next = setpoint_reg;
      step_next = step_reg;
      timing_next = timing_reg;
      tmr_load = 1'b0;
      tmr_run = 1'b0;

      unique case (state_reg)
         sfs_pkg::ST_CHARGE: begin
            setpoint_next = '0;
            timing_next = 1'b0;
            // start only at turn-on level with brown-out ok
            // level test: a supply already at turn-on starts at once
            if (cmp.vcc_at_on && cmp.bo_high) begin
               state_next = sfs_pkg::ST_SOFTSTART;
               step_next = STEP_LOAD;
            end
         end
         sfs_pkg::ST_SOFTSTART, sfs_pkg::ST_RUN, sfs_pkg::ST_RETRY: begin
            // soft-start ramp, one setpoint step per interval
            if (!at_max) begin
               if (step_reg <= SW'(1)) begin
                  setpoint_next = setpoint_reg + 1'b1;
                  step_next = STEP_LOAD;
               end else begin
                  step_next = step_reg - 1'b1;
               end
            end else if (state_reg == sfs_pkg::ST_SOFTSTART) begin
               state_next = sfs_pkg::ST_RUN;
            end
            if (state_reg == sfs_pkg::ST_RETRY) begin
               tmr_run = 1'b1;
               // retry end decides burst or normal running
               if (tmr_done) begin
                  if (at_max) begin
                     state_next = sfs_pkg::ST_OFF;
                     periods_next = 4'(OFF_PERIODS);
                     tmr_load = 1'b1;
                  end else begin
                     state_next = sfs_pkg::ST_RUN;
                     timing_next = 1'b0;
                  end
               end
            end else begin
               if (at_max && !flag_d_reg && !timing_reg) begin
                  tmr_load = 1'b1;
                  timing_next = 1'b1;
               end else if (timing_reg) begin
                  tmr_run = 1'b1;
                  // flag still set at end enters off period
                  if (tmr_done) begin
                     timing_next = 1'b0;
                     if (at_max) begin
                        state_next = sfs_pkg::ST_OFF;
                        periods_next = 4'(OFF_PERIODS);
                        tmr_load = 1'b1;
                     end
                  end
               end
            end
         end
         sfs_pkg::ST_OFF: begin
            setpoint_next = '0;
            tmr_run = 1'b1;
            if (tmr_done) begin
               if (periods_reg <= 4'h1) begin
                  state_next = sfs_pkg::ST_RETRY;
                  periods_next = 4'h0;
                  step_next = STEP_LOAD;
               end else begin
                  periods_next = periods_reg - 4'h1;
               end
               tmr_load = 1'b1;
            end
         end
         sfs_pkg::ST_LATCHED: begin
            setpoint_next = '0;
         end
      endcase

      // clamp overcurrent forces a full off period
      if (cmp.clamp_trip && state_reg != sfs_pkg::ST_LATCHED &&
          state_reg != sfs_pkg::ST_OFF) begin
         state_next = sfs_pkg::ST_OFF;
         periods_next = 4'(OFF_PERIODS);
         setpoint_next = '0;
         timing_next = 1'b0;
         tmr_load = 1'b1;
      end
      // undervoltage or brown-out stops pulses at once
      // only pulsing states fall back; off and latched keep their course
      if ((cmp.vcc_below_min || !cmp.bo_high) &&
          (state_reg == sfs_pkg::ST_SOFTSTART ||
           state_reg == sfs_pkg::ST_RUN ||
           state_reg == sfs_pkg::ST_RETRY)) begin
         state_next = sfs_pkg::ST_CHARGE;
         setpoint_next = '0;
         timing_next = 1'b0;
      end
      // latch-off wins over everything until reset
      if (cmp.bo_latch) begin
         state_next = sfs_pkg::ST_LATCHED;
         setpoint_next = '0;
         timing_next = 1'b0;
      end
   end

   // state, ramp and timer bookkeeping
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= sfs_pkg::ST_CHARGE;
         periods_reg <= 4'h0;
         setpoint_reg <= '0;
         step_reg <= '0;
         timing_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         periods_reg <= periods_next;
         setpoint_reg <= setpoint_next;
         step_reg <= step_next;
         timing_reg <= timing_next;
      end
   end

   logic pulsing;
   assign pulsing = (state_reg == sfs_pkg::ST_SOFTSTART) ||
                    (state_reg == sfs_pkg::ST_RUN) ||
                    (state_reg == sfs_pkg::ST_RETRY);

   // source runs while neither pulsing nor latched, by supply hysteresis
   // reduced level below the low supply threshold
   assign reduced_startup_current = !pulsing && src_on_reg &&
                                    (state_reg != sfs_pkg::ST_LATCHED) &&
                                    !cmp.vcc_above_low;
   assign nominal_startup_current = !pulsing && src_on_reg &&
                                    (state_reg != sfs_pkg::ST_LATCHED) &&
                                    cmp.vcc_above_low;
   // hysteresis source follows the brown-out signal
   assign brownout_offset_current = cmp.bo_high;
   // pulses gated by brown-out as well as state
   assign drive_enable = pulsing && cmp.bo_high && !cmp.vcc_below_min;
   assign peak_setpoint = setpoint_reg;
   assign peak_limit_flag = at_max;
   assign fault_burst = (state_reg == sfs_pkg::ST_OFF) ||
                        (state_reg == sfs_pkg::ST_RETRY);
   assign latched_off = (state_reg == sfs_pkg::ST_LATCHED);
endmodule

/* design/sfs_consts.svh */
// timing counts and fixed values of the switcher fault supervisor
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_CLK_HZ 100000000
`define SFS_SOFTSTART_US 1000
`define SFS_SOFTSTART_CYC ((`SFS_SOFTSTART_US * (`SFS_CLK_HZ / 1000000)))
`define SFS_TIMER_MS 55
`define SFS_TIMER_CYC ((`SFS_TIMER_MS * (`SFS_CLK_HZ / 1000)))
`define SFS_OFF_PERIODS 8
`define SFS_SETPOINT_W 8
`define SFS_SETPOINT_MAX 8'hFF
`endif

/* design/sfs_pkg.sv */
// types of the switcher fault supervisor
package sfs_pkg;
   typedef enum logic [2:0] {
      ST_CHARGE,
      ST_SOFTSTART,
      ST_RUN,
      ST_OFF,
      ST_RETRY,
      ST_LATCHED
   } sfs_state_e;

   // synchronised comparator decisions
   typedef struct packed {
      logic vcc_above_low;
      logic vcc_at_on;
      logic vcc_below_min;
      logic bo_high;
      logic bo_latch;
      logic clamp_trip;
   } sfs_cmp_s;
endpackage

/* design/sfs_sync.sv */
// two flip-flop synchroniser for one comparator input
module sfs_sync (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule

/* design/sfs_counter.sv */
// down counter loaded with a period, flags the end of the period
module sfs_counter #(
   parameter int WIDTH = 24
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic load,
   input wire logic [WIDTH-1:0] period,
   input wire logic run,
   output logic done
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = period;
      end else if (run && cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // done ignores load, so a reload on done forms no combinational loop
   assign done = run && (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

/* verification/sfs_front_model.sv */
// model of the analog front end: comparator decisions from set levels
module sfs_front_model (
   input wire logic [1:0] vcc_code,
   input wire logic bulk_ok,
   input wire logic latch_req,
   input wire logic clamp_req,
   output sfs_pkg::sfs_cmp_s cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   // supply code: 0 under low, 1 under min, 2 operating, 3 turn-on level
   assign cmp.vcc_above_low = vcc_code != 2'h0;
   assign cmp.vcc_at_on = vcc_code == 2'h3;
   assign cmp.vcc_below_min = vcc_code < 2'h2;
   assign cmp.bo_high = bulk_ok;
   assign cmp.bo_latch = latch_req;
   assign cmp.clamp_trip = clamp_req;
endmodule

/* verification/sfs_supervisor_assertions.sv */
// port checker of the switcher fault supervisor
module sfs_supervisor_checker (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic vcc_above_low_in,
   input wire logic vcc_at_on_in,
   input wire logic vcc_below_min_in,
   input wire logic bo_high_in,
   input wire logic bo_latch_in,
   input wire logic clamp_trip_in,
   input wire logic reduced_startup_current,
   input wire logic nominal_startup_current,
   input wire logic brownout_offset_current,
   input wire logic drive_enable,
   input wire logic [7:0] peak_setpoint,
   input wire logic peak_limit_flag,
   input wire logic fault_burst,
   input wire logic latched_off
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] age_reg;
   logic [1:0] age_next;
   // cycles since reset, so that sync history is valid
   always_comb begin
      age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
      if (srst) begin
         age_next = 2'h0;
      end
   end
   always_ff @(posedge sys_clk) begin
      age_reg <= age_next;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_ramp_step;
      drive_enable && peak_setpoint != 8'hFF ##1 drive_enable;
   endsequence
   property p_src_level;
      (reduced_startup_current || nominal_startup_current) && age_reg == 2'h3
         |-> nominal_startup_current == $past(vcc_above_low_in, 2);
   endproperty
   property p_flag_max;
      peak_limit_flag == (peak_setpoint == 8'hFF);
   endproperty
   property p_pulse_on;
      $rose(drive_enable) && !fault_burst
         |-> $past(vcc_at_on_in, 3) || $past(vcc_at_on_in, 4);
   endproperty
   property p_ramp;
      s_ramp_step |-> peak_setpoint >= $past(peak_setpoint)
         && peak_setpoint - $past(peak_setpoint) <= 8'h01;
   endproperty
   property p_timer_hold;
      $rose(peak_limit_flag) && !fault_burst |-> !fault_burst [*8];
   endproperty
   property p_undervoltage_lockout;
      vcc_below_min_in ##1 vcc_below_min_in |-> ##[1:3] !drive_enable;
   endproperty
   property p_brownout;
      !bo_high_in ##1 !bo_high_in |-> ##[1:3] !drive_enable;
   endproperty
   property p_offset;
      age_reg == 2'h3 |-> brownout_offset_current == $past(bo_high_in, 2);
   endproperty
   property p_latch;
      bo_latch_in |-> ##[2:4] latched_off && !drive_enable;
   endproperty
   property p_clamp;
      drive_enable && clamp_trip_in ##1 clamp_trip_in
         |-> ##[1:3] !drive_enable;
   endproperty
   a_src_level: assert property (p_src_level)
      else $error("startup source level wrong");
   a_flag_max: assert property (p_flag_max)
      else $error("peak-limit flag not tied to maximum");
   a_pulse_on: assert property (p_pulse_on)
      else $error("pulses enabled without turn-on level");
   a_ramp: assert property (p_ramp)
      else $error("setpoint ramp step wrong");
   a_timer_hold: assert property (p_timer_hold)
      else $error("burst started before timer ran");
   a_undervoltage_lockout: assert property (p_undervoltage_lockout)
      else $error("pulses kept in lockout");
   a_brownout: assert property (p_brownout)
      else $error("pulses kept in brown-out");
   a_offset: assert property (p_offset)
      else $error("offset current does not follow brown-out");
   a_latch: assert property (p_latch)
      else $error("latch-off not taken");
   a_clamp: assert property (p_clamp)
      else $error("pulses kept on clamp trip");
endmodule
bind sfs_supervisor sfs_supervisor_checker chk_u (.sys_clk(sys_clk),
   .srst(srst), .vcc_above_low_in(vcc_above_low_in),
   .vcc_at_on_in(vcc_at_on_in), .vcc_below_min_in(vcc_below_min_in),
   .bo_high_in(bo_high_in), .bo_latch_in(bo_latch_in),
   .clamp_trip_in(clamp_trip_in),
   .reduced_startup_current(reduced_startup_current),
   .nominal_startup_current(nominal_startup_current),
   .brownout_offset_current(brownout_offset_current),
   .drive_enable(drive_enable), .peak_setpoint(peak_setpoint),
   .peak_limit_flag(peak_limit_flag), .fault_burst(fault_burst),
   .latched_off(latched_off));

/* verification/tb_sfs_supervisor.sv */
// self-checking bench of the switcher fault supervisor
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin \
   bad_count++; $display("mismatch at %0t: %s", $time, m); end end
module tb_sfs_supervisor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TCYC = 50;
   localparam int OFFC = 8 * TCYC;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] vcc_code = 2'h0;
   logic bulk_ok = 1'b1;
   logic latch_req = 1'b0;
   logic clamp_req = 1'b0;
   sfs_pkg::sfs_cmp_s cmp;
   logic red_src, nom_src, offset_on, drive_enable;
   logic [7:0] peak_setpoint;
   logic peak_limit_flag, fault_burst, latched_off;
   int bad_count = 0;
   int num_checks = 0;
   always #5 sys_clk = ~sys_clk;
   sfs_front_model fe_u (.vcc_code(vcc_code), .bulk_ok(bulk_ok),
      .latch_req(latch_req), .clamp_req(clamp_req), .cmp(cmp));
   sfs_supervisor #(.TIMER_CYC(TCYC), .SOFTSTART_CYC(510), .OFF_PERIODS(8))
      dut_u (.sys_clk(sys_clk), .srst(srst),
      .vcc_above_low_in(cmp.vcc_above_low), .vcc_at_on_in(cmp.vcc_at_on),
      .vcc_below_min_in(cmp.vcc_below_min), .bo_high_in(cmp.bo_high),
      .bo_latch_in(cmp.bo_latch), .clamp_trip_in(cmp.clamp_trip),
      .reduced_startup_current(red_src), .nominal_startup_current(nom_src),
      .brownout_offset_current(offset_on), .drive_enable(drive_enable),
      .peak_setpoint(peak_setpoint), .peak_limit_flag(peak_limit_flag),
      .fault_burst(fault_burst), .latched_off(latched_off));
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wait_on(ref logic s, input logic v, input int lim,
      output int n);
      n = 0;
      while (s !== v && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic restart();
      srst = 1'b1;
      vcc_code = 2'h0;
      bulk_ok = 1'b1;
      latch_req = 1'b0;
      clamp_req = 1'b0;
      cyc(12);
      srst = 1'b0;
      cyc(4);
   endtask
   task automatic power_on();
      int n;
      vcc_code = 2'h3;
      wait_on(drive_enable, 1'b1, 10, n);
      `CHK(drive_enable, 1'b1, "no pulses at turn-on")
      vcc_code = 2'h2;
      cyc(20);
   endtask
   task automatic t_startup();
      int n;
      restart();
      `CHK(red_src, 1'b1, "reduced source off")
      vcc_code = 2'h1;
      cyc(1);
      `CHK(nom_src, 1'b0, "source moved before sync")
      cyc(3);
      `CHK(nom_src, 1'b1, "nominal source off")
      power_on();
      wait_on(peak_limit_flag, 1'b1, 600, n);
      `CHK(n > 470 && n < 500, 1'b1, "soft-start length")
      `CHK(peak_setpoint, 8'hFF, "setpoint below maximum")
      wait_on(fault_burst, 1'b1, TCYC + 10, n);
      `CHK(n >= TCYC - 5 && fault_burst, 1'b1, "fault timer")
      `CHK(drive_enable, 1'b0, "pulses in off period")
      vcc_code = 2'h1;
      cyc(4);
      `CHK(red_src | nom_src, 1'b1, "no self-supply")
      vcc_code = 2'h2;
      wait_on(drive_enable, 1'b1, OFFC + 20, n);
      `CHK(n >= OFFC - 20, 1'b1, "off period short")
      `CHK(fault_burst, 1'b1, "retry outside burst")
      wait_on(fault_burst, 1'b0, TCYC + 10, n);
      `CHK(n >= TCYC - 5 && !fault_burst, 1'b1, "retry length")
      `CHK(drive_enable, 1'b1, "no return to run")
   endtask
   task automatic t_undervoltage_lockout();
      int n;
      restart();
      power_on();
      vcc_code = 2'h1;
      wait_on(drive_enable, 1'b0, 4, n);
      `CHK(drive_enable, 1'b0, "pulses in lockout")
      vcc_code = 2'h2;
      cyc(30);
      `CHK(drive_enable, 1'b0, "pulses without turn-on")
   endtask
   task automatic t_brownout();
      int n;
      restart();
      power_on();
      `CHK(offset_on, 1'b1, "offset current off")
      bulk_ok = 1'b0;
      wait_on(drive_enable, 1'b0, 4, n);
      `CHK(drive_enable, 1'b0, "pulses in brown-out")
      `CHK(offset_on, 1'b0, "offset current on")
      bulk_ok = 1'b1;
      cyc(30);
      `CHK(drive_enable, 1'b0, "pulses before turn-on")
      vcc_code = 2'h3;
      wait_on(drive_enable, 1'b1, 10, n);
      `CHK(drive_enable, 1'b1, "no restart")
   endtask
   task automatic t_clamp();
      int n;
      restart();
      power_on();
      clamp_req = 1'b1;
      cyc(2);
      clamp_req = 1'b0;
      wait_on(drive_enable, 1'b0, 4, n);
      `CHK(drive_enable, 1'b0, "pulses on clamp trip")
      wait_on(drive_enable, 1'b1, OFFC + 20, n);
      `CHK(n >= OFFC - 20 && drive_enable, 1'b1, "clamp wait")
   endtask
   task automatic t_latch();
      restart();
      power_on();
      latch_req = 1'b1;
      cyc(5);
      latch_req = 1'b0;
      vcc_code = 2'h3;
      cyc(50);
      `CHK({latched_off, drive_enable}, 2'h2, "latch lost")
      restart();
      `CHK(latched_off, 1'b0, "latch kept over reset")
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      cyc(20000);
      bad_count++;
      $display("mismatch at %0t: %s", $time, "watchdog expired");
      close_out();
   end
   initial begin
      t_startup();
      t_undervoltage_lockout();
      t_brownout();
      t_clamp();
      t_latch();
      close_out();
   end
endmodule
